/* File: verilog/trap_state_pkg.sv */
// Notes on behaviour
// - software scratch word, full width, read/write
// - return pc bit 0 always zero
// - fixed 32-bit alignment zeroes return pc bits 1:0
// - switchable alignment at 32 masks bit 1 on read
// - masked bit 1 still stored, reappears later
// - return pc holds every valid address
// - trap loads return pc, otherwise only software
// - trap writes cause, otherwise only software
// - cause top bit set for interrupts only
// - cause code stores supported code width only
// - interrupt codes 1,3,5,7,9,11
// - exception codes 0..7, page faults 12,13,15
// - environment call codes 8, 9, 11
// - never produce reserved exception codes
// - loads use load codes, stores/atomics store codes
// - fixed synchronous exception priority order
// - translation fault ranks above physical access fault
// - data misaligned rank chosen by parameter
// - misaligned target lowest of instruction address faults
// - all breakpoint kinds report code 3
// - privilege violations report illegal instruction code
// - machine interrupt priority external, software, timer
//
// shared constants for the machine trap state block.
// assumes a 32-bit classic bus slave and a 64-bit register model.
package trap_state_pkg;

  localparam int        ADR_W          = 8;     // byte address width on the bus
  localparam int        CODE_W         = 6;     // stored exception code width
  // register byte offsets, one 32-bit word each
  localparam [7:0]      OFS_SCRATCH_LO = 8'h00;
  localparam [7:0]      OFS_SCRATCH_HI = 8'h04;
  localparam [7:0]      OFS_EPC_LO     = 8'h08;
  localparam [7:0]      OFS_EPC_HI     = 8'h0c;
  localparam [7:0]      OFS_CAUSE_LO   = 8'h10;
  localparam [7:0]      OFS_CAUSE_HI   = 8'h14;
  localparam [7:0]      OFS_CTRL       = 8'h18;
  localparam int        CTRL_ALIGN16   = 0;     // control bit: 16-bit alignment on
  // values after reset
  localparam [63:0]     RST_SCRATCH    = 64'h0;
  localparam [63:0]     RST_EPC        = 64'h0;
  localparam [5:0]      RST_CODE       = 6'h0;
  localparam            RST_IRQ        = 1'b0;
  localparam            RST_ALIGN16    = 1'b1;
  // interrupt cause codes
  localparam [5:0]      CODE_S_SOFT    = 6'h01;
  localparam [5:0]      CODE_M_SOFT    = 6'h03;
  localparam [5:0]      CODE_S_TIMER   = 6'h05;
  localparam [5:0]      CODE_M_TIMER   = 6'h07;
  localparam [5:0]      CODE_S_EXT     = 6'h09;
  localparam [5:0]      CODE_M_EXT     = 6'h0b;
  // exception cause codes
  localparam [5:0]      CODE_FETCH_MIS = 6'h00;
  localparam [5:0]      CODE_FETCH_AF  = 6'h01;
  localparam [5:0]      CODE_ILLEGAL   = 6'h02;
  localparam [5:0]      CODE_BREAK     = 6'h03;
  localparam [5:0]      CODE_LOAD_MIS  = 6'h04;
  localparam [5:0]      CODE_LOAD_AF   = 6'h05;
  localparam [5:0]      CODE_STORE_MIS = 6'h06;
  localparam [5:0]      CODE_STORE_AF  = 6'h07;
  localparam [5:0]      CODE_ECALL_U   = 6'h08;
  localparam [5:0]      CODE_ECALL_S   = 6'h09;
  localparam [5:0]      CODE_ECALL_M   = 6'h0b;
  localparam [5:0]      CODE_FETCH_PF  = 6'h0c;
  localparam [5:0]      CODE_LOAD_PF   = 6'h0d;
  localparam [5:0]      CODE_STORE_PF  = 6'h0f;
  // privilege encodings of the calling mode
  localparam [1:0]      PRIV_U         = 2'h0;
  localparam [1:0]      PRIV_S         = 2'h1;

  // byte-lane merge of a bus write into a stored word
  function automatic logic [31:0] merge_lanes(input logic [31:0] old_w,
                                              input logic [31:0] new_w,
                                              input logic [3:0]  sel);
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
        res[8*b +: 8] = new_w[8*b +: 8];
    end
    return res;
  endfunction : merge_lanes

endpackage : trap_state_pkg

/* File: verilog/irq_priority_sel.sv */
// fixed-priority pick among the six standard interrupt sources.
// assumes pending bits are already enabled and routed to machine mode.
`timescale 1ns/10ps
module irq_priority_sel
  import trap_state_pkg::*;
(
  input  wire logic              machine_external_irq_i,
  input  wire logic              machine_software_irq_i,
  input  wire logic              machine_timer_irq_i,
  input  wire logic              supervisor_external_irq_i,
  input  wire logic              supervisor_software_irq_i,
  input  wire logic              supervisor_timer_irq_i,
  output logic                   irq_valid_o,
  output logic [CODE_W-1:0]      irq_code_o
);

  // external before software before timer, machine before supervisor
  always_comb
  begin
    irq_valid_o = 1'b1;
    if (machine_external_irq_i)            irq_code_o = CODE_M_EXT;
    else if (machine_software_irq_i)       irq_code_o = CODE_M_SOFT;
    else if (machine_timer_irq_i)          irq_code_o = CODE_M_TIMER;
    else if (supervisor_external_irq_i)    irq_code_o = CODE_S_EXT;
    else if (supervisor_software_irq_i)    irq_code_o = CODE_S_SOFT;
    else if (supervisor_timer_irq_i)       irq_code_o = CODE_S_TIMER;
    else
    begin
      irq_valid_o = 1'b0;                  // nothing pending
      irq_code_o  = RST_CODE;
    end
  end

endmodule : irq_priority_sel

/* File: verilog/exc_priority_sel.sv */
// picks one synchronous exception when an instruction raises several.
// assumes the pipeline flags every fault of the same instruction at once.
`timescale 1ns/10ps
module exc_priority_sel
  import trap_state_pkg::*;
#(
  parameter bit MISALIGN_FIRST = 1'b1     // data misaligned above data faults
)
(
  input  wire logic              fetch_breakpoint_i,
  input  wire logic              fetch_walk_page_fault_i,
  input  wire logic              fetch_walk_access_fault_i,
  input  wire logic              fetch_access_fault_i,
  input  wire logic              illegal_i,
  input  wire logic              priv_violation_i,
  input  wire logic              target_misaligned_i,
  input  wire logic              ecall_i,
  input  wire logic [1:0]        ecall_mode_i,
  input  wire logic              env_break_i,
  input  wire logic              data_breakpoint_i,
  input  wire logic              mem_is_store_i,
  input  wire logic              mem_misaligned_i,
  input  wire logic              mem_walk_page_fault_i,
  input  wire logic              mem_walk_access_fault_i,
  input  wire logic              mem_access_fault_i,
  output logic                   exc_valid_o,
  output logic [CODE_W-1:0]      exc_code_o
);

  // store, conditional store and atomics share store codes
  logic [CODE_W-1:0] c_mis, c_pf, c_af;   // load or store flavour
  logic [CODE_W-1:0] c_ecall;             // by calling mode

  // one chain in table order; only standard codes can leave it
  always_comb
  begin
    c_mis   = mem_is_store_i ? CODE_STORE_MIS : CODE_LOAD_MIS;
    c_pf    = mem_is_store_i ? CODE_STORE_PF  : CODE_LOAD_PF;
    c_af    = mem_is_store_i ? CODE_STORE_AF  : CODE_LOAD_AF;
    c_ecall = (ecall_mode_i == PRIV_U) ? CODE_ECALL_U :
              (ecall_mode_i == PRIV_S) ? CODE_ECALL_S : CODE_ECALL_M;
    exc_valid_o = 1'b1;
    if (fetch_breakpoint_i)                 exc_code_o = CODE_BREAK;
    else if (fetch_walk_page_fault_i)       exc_code_o = CODE_FETCH_PF;
    else if (fetch_walk_access_fault_i)     exc_code_o = CODE_FETCH_AF;
    else if (fetch_access_fault_i)          exc_code_o = CODE_FETCH_AF;
    else if (illegal_i || priv_violation_i) exc_code_o = CODE_ILLEGAL;
    else if (target_misaligned_i)           exc_code_o = CODE_FETCH_MIS;
    else if (ecall_i)                       exc_code_o = c_ecall;
    else if (env_break_i)                   exc_code_o = CODE_BREAK;
    else if (data_breakpoint_i)             exc_code_o = CODE_BREAK;
    else if (MISALIGN_FIRST && mem_misaligned_i) exc_code_o = c_mis;
    else if (mem_walk_page_fault_i)         exc_code_o = c_pf;
    else if (mem_walk_access_fault_i)       exc_code_o = c_af;
    else if (mem_access_fault_i)            exc_code_o = c_af;
    else if (mem_misaligned_i)              exc_code_o = c_mis;
    else
    begin
      exc_valid_o = 1'b0;
      exc_code_o  = RST_CODE;
    end
  end

endmodule : exc_priority_sel

/* File: verilog/machine_trap_state_regs.sv */
// machine trap state: scratch, trap return pc and trap cause registers,
// reached over a classic 32-bit bus slave, loaded by the pipeline on traps.
// assumes the pipeline pulses trap_take_i for one cycle per trap taken.
`timescale 1ns/10ps
module machine_trap_state_regs
  import trap_state_pkg::*;
#(
  parameter int XLEN           = 64,    // machine_register_width, 32 or 64
  parameter bit ALIGN_SWITCH   = 1'b1,  // 16/32 alignment can switch
  parameter bit MISALIGN_FIRST = 1'b1   // data misaligned above data faults
)
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // classic bus slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADR_W-1:0]  wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic [31:0]            wb_dat_o,
  output logic                   wb_ack_o,
  // pipeline side: trap entry
  input  wire logic              trap_take_i,
  input  wire logic [XLEN-1:0]   trap_pc_i,
  // pending interrupts destined for machine mode
  input  wire logic              machine_external_irq_i,
  input  wire logic              machine_software_irq_i,
  input  wire logic              machine_timer_irq_i,
  input  wire logic              supervisor_external_irq_i,
  input  wire logic              supervisor_software_irq_i,
  input  wire logic              supervisor_timer_irq_i,
  // synchronous exception flags of the retiring instruction
  input  wire logic              fetch_breakpoint_i,
  input  wire logic              fetch_walk_page_fault_i,
  input  wire logic              fetch_walk_access_fault_i,
  input  wire logic              fetch_access_fault_i,
  input  wire logic              illegal_i,
  input  wire logic              priv_violation_i,
  input  wire logic              target_misaligned_i,
  input  wire logic              ecall_i,
  input  wire logic [1:0]        ecall_mode_i,
  input  wire logic              env_break_i,
  input  wire logic              data_breakpoint_i,
  input  wire logic              mem_is_store_i,
  input  wire logic              mem_misaligned_i,
  input  wire logic              mem_walk_page_fault_i,
  input  wire logic              mem_walk_access_fault_i,
  input  wire logic              mem_access_fault_i,
  // pipeline side: results
  output logic                   trap_request_o,
  output logic [XLEN-1:0]        return_pc_o
);

  // refuse widths the register model cannot hold
  if (!(XLEN == 32 || XLEN == 64))
  begin : g_xlen_check
    $error("XLEN must be 32 or 64");
  end

  // bits beyond the configured width stay zero
  localparam [63:0] XMASK = (XLEN == 64) ? 64'hffff_ffff_ffff_ffff
                                         : 64'h0000_0000_ffff_ffff;
  localparam int    IRQ_BIT = XLEN - 1;   // interrupt flag is the sign bit

  // widen a pipeline pc to the 64-bit model
  function automatic logic [63:0] widen(input logic [XLEN-1:0] v);
    logic [63:0] r;
    r = 64'h0;
    r[XLEN-1:0] = v;
    return r;
  endfunction : widen

  // apply a bus write to one half of a 64-bit register
  function automatic logic [63:0] write_half(input logic [63:0] old_v,
                                             input logic        hi,
                                             input logic [31:0] d,
                                             input logic [3:0]  sel);
    logic [63:0] r;
    r = old_v;
    if (hi)
      r[63:32] = merge_lanes(old_v[63:32], d, sel);
    else
      r[31:0]  = merge_lanes(old_v[31:0], d, sel);
    return r & XMASK;
  endfunction : write_half

  // trap cause selection
  logic              irq_valid;            // some interrupt pending
  logic [CODE_W-1:0] irq_code;             // winning interrupt code
  logic              exc_valid;            // some exception flagged
  logic [CODE_W-1:0] exc_code;             // winning exception code

  irq_priority_sel u_irq_sel (
    .machine_external_irq_i    (machine_external_irq_i),
    .machine_software_irq_i    (machine_software_irq_i),
    .machine_timer_irq_i       (machine_timer_irq_i),
    .supervisor_external_irq_i (supervisor_external_irq_i),
    .supervisor_software_irq_i (supervisor_software_irq_i),
    .supervisor_timer_irq_i    (supervisor_timer_irq_i),
    .irq_valid_o               (irq_valid),
    .irq_code_o                (irq_code)
  );

  exc_priority_sel #(
    .MISALIGN_FIRST (MISALIGN_FIRST)
  ) u_exc_sel (
    .fetch_breakpoint_i        (fetch_breakpoint_i),
    .fetch_walk_page_fault_i   (fetch_walk_page_fault_i),
    .fetch_walk_access_fault_i (fetch_walk_access_fault_i),
    .fetch_access_fault_i      (fetch_access_fault_i),
    .illegal_i                 (illegal_i),
    .priv_violation_i          (priv_violation_i),
    .target_misaligned_i       (target_misaligned_i),
    .ecall_i                   (ecall_i),
    .ecall_mode_i              (ecall_mode_i),
    .env_break_i               (env_break_i),
    .data_breakpoint_i         (data_breakpoint_i),
    .mem_is_store_i            (mem_is_store_i),
    .mem_misaligned_i          (mem_misaligned_i),
    .mem_walk_page_fault_i     (mem_walk_page_fault_i),
    .mem_walk_access_fault_i   (mem_walk_access_fault_i),
    .mem_access_fault_i        (mem_access_fault_i),
    .exc_valid_o               (exc_valid),
    .exc_code_o                (exc_code)
  );

  // tells the pipeline a trap is due; handshake, so combinational
  assign trap_request_o = irq_valid | exc_valid;

  // register state
  logic [63:0]       scratch_reg, scratch_next;   // software scratch
  logic [63:0]       epc_reg, epc_next;           // stored return pc
  logic              cause_irq_reg, cause_irq_next;   // interrupt flag
  logic [CODE_W-1:0] cause_code_reg, cause_code_next; // exception code
  logic              align16_reg, align16_next;   // 16-bit alignment on
  logic              ack_reg, ack_next;           // bus answer
  logic [31:0]       rdat_reg, rdat_next;         // bus read data
  logic [63:0]       ret_pc_reg, ret_pc_next;     // pc for the return

  // bus decode helpers
  logic              bus_req;                     // new request seen
  logic              wr_hit;                      // write being taken
  logic [63:0]       epc_view;                    // return pc as read
  logic [63:0]       cause_view;                  // cause as read

  // a request is taken once: ack_reg blocks the second cycle
  assign bus_req = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign wr_hit  = bus_req & wb_we_i;

  // read view of the return pc with alignment masking
  always_comb
  begin
    epc_view = epc_reg;
    epc_view[0] = 1'b0;
    if (!ALIGN_SWITCH)
      epc_view[1] = 1'b0;
    else if (!align16_reg)
      epc_view[1] = 1'b0;
    epc_view = epc_view & XMASK;
  end

  // read view of the cause: flag in the sign bit, code in the low bits
  always_comb
  begin
    cause_view = 64'h0;
    cause_view[CODE_W-1:0] = cause_code_reg;
    cause_view[IRQ_BIT]    = cause_irq_reg;
  end

  // next value of the scratch register: software writes only
  always_comb
  begin
    scratch_next = scratch_reg;
    if (wr_hit && wb_adr_i == OFS_SCRATCH_LO)
      scratch_next = write_half(scratch_reg, 1'b0, wb_dat_i, wb_sel_i);
    else if (wr_hit && wb_adr_i == OFS_SCRATCH_HI)
      scratch_next = write_half(scratch_reg, 1'b1, wb_dat_i, wb_sel_i);
    // traps and returns leave it alone
  end

  // next value of the return pc; a trap in the same cycle wins over
  // a software write, since the trap is the later architectural event
  always_comb
  begin
    epc_next = epc_reg;
    if (trap_take_i)
      epc_next = widen(trap_pc_i);
    else if (wr_hit && wb_adr_i == OFS_EPC_LO)
      epc_next = write_half(epc_reg, 1'b0, wb_dat_i, wb_sel_i);
    else if (wr_hit && wb_adr_i == OFS_EPC_HI)
      epc_next = write_half(epc_reg, 1'b1, wb_dat_i, wb_sel_i);
    // full width kept, so any valid address fits
    epc_next[0] = 1'b0;
    if (!ALIGN_SWITCH)
      epc_next[1] = 1'b0;
    // with switching, bit 1 is stored as written
  end

  // next value of the cause register
  always_comb
  begin
    logic [63:0] cw;                               // cause after bus write
    cw = cause_view;
    cause_irq_next  = cause_irq_reg;
    cause_code_next = cause_code_reg;
    if (trap_take_i)
    begin
      // interrupts are taken ahead of exceptions at a boundary
      cause_irq_next  = irq_valid;
      cause_code_next = irq_valid ? irq_code : exc_code;
    end
    else if (wr_hit && (wb_adr_i == OFS_CAUSE_LO || wb_adr_i == OFS_CAUSE_HI))
    begin
      cw = write_half(cause_view, wb_adr_i == OFS_CAUSE_HI, wb_dat_i, wb_sel_i);
      cause_irq_next  = cw[IRQ_BIT];
      // upper code bits are dropped, any code that fits CODE_W bits sticks
      cause_code_next = cw[CODE_W-1:0];
    end
  end

  // next value of the alignment control bit
  always_comb
  begin
    align16_next = align16_reg;
    if (wr_hit && wb_adr_i == OFS_CTRL && wb_sel_i[0])
      align16_next = wb_dat_i[CTRL_ALIGN16];
    if (!ALIGN_SWITCH)
      align16_next = 1'b0;                         // fixed 32-bit alignment
  end

  // bus answer and read data: one wait state, unmapped reads give zero
  always_comb
  begin
    ack_next  = bus_req;
    rdat_next = rdat_reg;
    if (bus_req)
    begin
      if (wb_adr_i == OFS_SCRATCH_LO)      rdat_next = scratch_reg[31:0];
      else if (wb_adr_i == OFS_SCRATCH_HI) rdat_next = scratch_reg[63:32];
      else if (wb_adr_i == OFS_EPC_LO)     rdat_next = epc_view[31:0];
      else if (wb_adr_i == OFS_EPC_HI)     rdat_next = epc_view[63:32];
      else if (wb_adr_i == OFS_CAUSE_LO)   rdat_next = cause_view[31:0];
      else if (wb_adr_i == OFS_CAUSE_HI)   rdat_next = cause_view[63:32];
      else if (wb_adr_i == OFS_CTRL)
      begin
        rdat_next = 32'h0;
        rdat_next[CTRL_ALIGN16] = align16_reg;
      end
      else
        rdat_next = 32'h0;                          // unmapped: acked, zero
    end
  end

  // return pc as seen by the trap return instruction, same masking
  always_comb
  begin
    ret_pc_next = epc_view;
  end

  // registers, one block per group
  // synchronous reset to constants
  // no logic in these blocks

  // scratch word
  // only the bus writes it
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      scratch_reg <= RST_SCRATCH;
    else
      scratch_reg <= scratch_next;
  end

  // stored return pc
  // bit 1 kept while masked
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      epc_reg <= RST_EPC;
    else
      epc_reg <= epc_next;
  end

  // cause flag and code
  // written together on a trap
  // or by a bus write
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cause_irq_reg  <= RST_IRQ;
      cause_code_reg <= RST_CODE;
    end
    else
    begin
      cause_irq_reg  <= cause_irq_next;
      cause_code_reg <= cause_code_next;
    end
  end

  // alignment control
  // stuck at 32-bit if no switch
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      align16_reg <= RST_ALIGN16 & ALIGN_SWITCH;
    else
      align16_reg <= align16_next;
  end

  // bus answer and read data
  // ack blocks a held strobe
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_reg  <= 1'b0;
      rdat_reg <= 32'h0;
    end
    else
    begin
      ack_reg  <= ack_next;
      rdat_reg <= rdat_next;
    end
  end

  // return pc port
  // keeps masking off the pipe path
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ret_pc_reg <= RST_EPC;
    else
      ret_pc_reg <= ret_pc_next;
  end

  // outputs straight from flip-flops
  assign wb_ack_o    = ack_reg;
  assign wb_dat_o    = rdat_reg;
  assign return_pc_o = ret_pc_reg[XLEN-1:0];

endmodule : machine_trap_state_regs

/* File: dv/trap_pipe_model.sv */
// pipeline stand-in: turns a bench request into a one-cycle trap pulse.
// assumes the bench holds the fault flags until the pulse is taken.
`timescale 1ns/10ps
module trap_pipe_model
(
  input  wire logic        clk_i,
  input  wire logic        go_i,              // bench asks for a trap
  input  wire logic [63:0] pc_i,              // pc to report
  output logic             trap_take_o = 1'b0, // one-cycle trap pulse
  output logic [63:0]      trap_pc_o = 64'h0   // pc, scrambled outside the pulse
);
  // idle pc flips every cycle so a stale value never passes for a real one
  always @(posedge clk_i)
  begin
    trap_take_o <= go_i;
    trap_pc_o   <= go_i ? pc_i : ~trap_pc_o;
  end
endmodule : trap_pipe_model

/* File: dv/trap_state_properties.sv */
// timing checks on the bus answer and the trap return pc port.
// assumes bench keeps the bus quiet while a trap is in flight.
`timescale 1ns/10ps
module trap_state_checker
  import trap_state_pkg::*;
#(
  parameter int XLEN = 64
)
(
  input wire logic             clk_i,
  input wire logic             rst_i,
  input wire logic             wb_cyc_i,
  input wire logic             wb_stb_i,
  input wire logic             wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [31:0]      wb_dat_o,
  input wire logic             wb_ack_o,
  input wire logic             trap_take_i,
  input wire logic [XLEN-1:0]  trap_pc_i,
  input wire logic [XLEN-1:0]  return_pc_o
);
  default clocking dc @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic bus_wr = wb_cyc_i && wb_stb_i && wb_we_i; // any write on the bus
  ack_timing_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus answer late");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
  epc_read_a: assert property (wb_ack_o && $past(!wb_we_i && wb_adr_i == OFS_EPC_LO)
    |-> wb_dat_o[0] == 1'b0) else $error("return pc bit 0 set");
  cause_flag_a: assert property (wb_ack_o && $past(!wb_we_i && wb_adr_i == OFS_CAUSE_HI)
    |-> wb_dat_o[30:0] == 31'h0) else $error("cause upper bits set");
  cause_code_a: assert property (wb_ack_o && $past(!wb_we_i && wb_adr_i == OFS_CAUSE_LO)
    |-> wb_dat_o[31:6] == 26'h0) else $error("cause code too wide");
  unmapped_read_a: assert property (wb_ack_o && $past(!wb_we_i && wb_adr_i == 8'h1c)
    |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
  ret_pc_bit0_a: assert property (return_pc_o[0] == 1'b0) else $error("pc bit 0 set");
  retpc_load_a: assert property (trap_take_i && !bus_wr ##1 !trap_take_i && !bus_wr
    |=> return_pc_o[XLEN-1:2] == $past(trap_pc_i[XLEN-1:2], 2)) else $error("pc not loaded");
  retpc_hold_a: assert property (!trap_take_i && !bus_wr ##1 !trap_take_i && !bus_wr
    |=> $stable(return_pc_o)) else $error("return pc moved");
endmodule : trap_state_checker
bind machine_trap_state_regs trap_state_checker #(.XLEN(XLEN)) chk (.clk_i, .rst_i,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .trap_take_i,
  .trap_pc_i, .return_pc_o);

/* File: dv/tb.sv */
// self-checking bench: bus reads of the trap state after driven traps.
// assumes a one-cycle bus answer and a pipeline model giving the pc only with its pulse.
`timescale 1ns/10ps
module tb;
  import trap_state_pkg::*;
  `define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fail_count++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, (a), (b)); end end
  logic        clk_i = 1'b0, rst_i = 1'b1, req = 1'b0, we = 1'b0, go = 1'b0, st = 1'b0;
  logic [7:0]  adr = 8'h0;
  logic [31:0] wdat = 32'h0, rdat, wd;
  logic [5:0]  irq = 6'h0;
  logic [13:0] ex = 14'h0;
  logic [1:0]  mode = 2'h0, m;
  logic [63:0] tpc_req = 64'h0, pc, tpc;
  logic        take, ack, s, treq;
  logic [31:0] dat_o;
  int          fail_count = 0, n_checks = 0, i;
  logic [5:0]  itab [6] = '{6'h0b, 6'h03, 6'h07, 6'h09, 6'h01, 6'h05};
  always #50 clk_i = ~clk_i;
  trap_pipe_model pm (.clk_i(clk_i), .go_i(go), .pc_i(tpc_req), .trap_take_o(take),
    .trap_pc_o(tpc));
  machine_trap_state_regs #(.XLEN(64), .ALIGN_SWITCH(1'b1), .MISALIGN_FIRST(1'b1)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .trap_take_i(take), .trap_pc_i(tpc), .machine_external_irq_i(irq[5]),
    .machine_software_irq_i(irq[4]), .machine_timer_irq_i(irq[3]),
    .supervisor_external_irq_i(irq[2]), .supervisor_software_irq_i(irq[1]),
    .supervisor_timer_irq_i(irq[0]), .fetch_breakpoint_i(ex[13]),
    .fetch_walk_page_fault_i(ex[12]), .fetch_walk_access_fault_i(ex[11]),
    .fetch_access_fault_i(ex[10]), .illegal_i(ex[9]), .priv_violation_i(ex[8]),
    .target_misaligned_i(ex[7]), .ecall_i(ex[6]), .ecall_mode_i(mode), .env_break_i(ex[5]),
    .data_breakpoint_i(ex[4]), .mem_is_store_i(st), .mem_misaligned_i(ex[3]),
    .mem_walk_page_fault_i(ex[2]), .mem_walk_access_fault_i(ex[1]),
    .mem_access_fault_i(ex[0]), .trap_request_o(treq), .return_pc_o());
  // expected cause code when flag vector is shifted right by i
  function automatic logic [5:0] exp_exc(input int k, input logic sv, input logic [1:0] mv);
    case (k)
      0, 8, 9: return 6'h03;
      1:       return 6'h0c;
      2, 3:    return 6'h01;
      4, 5:    return 6'h02;
      6:       return 6'h00;
      7:       return (mv == 2'h0) ? 6'h08 : (mv == 2'h1) ? 6'h09 : 6'h0b;
      10:      return sv ? 6'h06 : 6'h04;
      11:      return sv ? 6'h0f : 6'h0d;
      default: return sv ? 6'h07 : 6'h05;
    endcase
  endfunction : exp_exc
  task automatic print_verdict;
    if (fail_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  // one classic cycle, held until ack is sampled, bounded wait
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    req  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    for (n = 0; n < 20 && ack !== 1'b1; n++) @(posedge clk_i);
    rdat = dat_o;
    req <= 1'b0;
    if (ack !== 1'b1)
    begin
      fail_count++;
      print_verdict();
    end
  endtask : bus
  // flags held until the model's pulse has been sampled
  task automatic trap(input logic [63:0] p, input logic [5:0] iv, input logic [13:0] ev,
                      input logic sv, input logic [1:0] mv);
    @(posedge clk_i);
    go <= 1'b1;
    tpc_req <= p;
    irq <= iv;
    ex <= ev;
    st <= sv;
    mode <= mv;
    @(posedge clk_i);
    go <= 1'b0;
    `CHK(treq, |{iv, ev})
    repeat (2) @(posedge clk_i);
    irq <= 6'h0;
    ex <= 14'h0;
  endtask : trap
  initial
  begin
    void'($urandom(32'h2cad));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(1'b0, OFS_CTRL, 32'h0);
    `CHK(rdat[0], RST_ALIGN16)
    wd = $urandom;
    bus(1'b1, OFS_SCRATCH_LO, wd);
    bus(1'b1, OFS_SCRATCH_HI, ~wd);
    bus(1'b1, OFS_EPC_HI, wd);
    bus(1'b0, OFS_EPC_HI, 32'h0);
    `CHK(rdat, wd)
    bus(1'b1, OFS_EPC_LO, 32'hffffffff);
    bus(1'b0, OFS_EPC_LO, 32'h0);
    `CHK(rdat, 32'hfffffffe)
    bus(1'b1, OFS_CTRL, 32'h0);
    bus(1'b0, OFS_EPC_LO, 32'h0);
    `CHK(rdat, 32'hfffffffc)
    bus(1'b1, OFS_CTRL, 32'h1);
    bus(1'b0, OFS_EPC_LO, 32'h0);
    `CHK(rdat, 32'hfffffffe)
    // interrupts drop out highest first; exceptions pending too
    for (i = 0; i < 6; i++)
    begin
      pc = {$urandom, $urandom};
      trap(pc, 6'h3f >> i, 14'h3fff, 1'b0, 2'h0);
      bus(1'b0, OFS_CAUSE_LO, 32'h0);
      `CHK(rdat, {26'h0, itab[i]})
      bus(1'b0, OFS_CAUSE_HI, 32'h0);
      `CHK(rdat, 32'h80000000)
      bus(1'b0, OFS_EPC_LO, 32'h0);
      `CHK(rdat, pc[31:0] & 32'hfffffffe)
    end
    // exceptions drop out highest first, random kind and mode
    for (i = 0; i < 14; i++)
    begin
      s = 1'($urandom);
      m = 2'($urandom);
      trap({$urandom, $urandom}, 6'h0, 14'h3fff >> i, s, m);
      bus(1'b0, OFS_CAUSE_LO, 32'h0);
      `CHK(rdat, {26'h0, exp_exc(i, s, m)})
      bus(1'b0, OFS_CAUSE_HI, 32'h0);
      `CHK(rdat, 32'h0)
    end
    `CHK(treq, 1'b0)
    bus(1'b1, 8'h1c, wd);
    bus(1'b0, 8'h1c, 32'h0);
    `CHK(rdat, 32'h0)
    bus(1'b1, OFS_CAUSE_LO, 32'h0000000d);
    bus(1'b0, OFS_CAUSE_LO, 32'h0);
    `CHK(rdat, 32'h0000000d)
    bus(1'b0, OFS_SCRATCH_LO, 32'h0);
    `CHK(rdat, wd)
    bus(1'b0, OFS_SCRATCH_HI, 32'h0);
    `CHK(rdat, ~wd)
    print_verdict();
  end
endmodule : tb
